// ==== rtl/tx_burst_buffer_fetch.sv ====
// transmit burst fetch: enqueue register, header walk, word stream to the mac
// assumes a host-memory read port that answers with ack and data together
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`include "txb_params.svh"

// Contract
// - writing the enqueue register starts fetching the named host buffer
// - bits 15:0 give the byte count fetched from the buffer
// - bits 21:16 select the pre-allocated host buffer
// - bit 24 asks for an interrupt when the fetch completes
// - first word of the buffer is a transmit header
// - packet bytes start right after the header, no gap
// - header kind 0x2 marks a transmit request
// - header length counts the packet bytes that follow
// - next header position comes from the current length
// - every header starts on an eight-byte boundary
// - only the transmit header kind is recognised
// - vlan table index picks the tag-control entry
// - vlan insert bit builds a tag from that entry for the packet
module tx_burst_buffer_fetch #(
  parameter int VIDX_W = 4
) (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [31:0] REG_RDATA_OUT,
  output logic IRQ_OUT,
  output logic MEM_RD_REQ_OUT,
  output logic [5:0] MEM_BUF_SEL_OUT,
  output logic [15:0] MEM_ADDR_OUT,
  input wire logic MEM_RD_ACK_IN,
  input wire logic [31:0] MEM_RDATA_IN,
  output logic TX_VALID_OUT,
  output logic [31:0] TX_DATA_OUT,
  output logic [2:0] TX_BYTES_OUT,
  output logic TX_FIRST_OUT,
  output logic TX_LAST_OUT,
  output logic TX_VLAN_EN_OUT,
  output logic [31:0] TX_VLAN_TAG_OUT,
  input wire logic TX_READY_IN
);
  // ------------------------------------------------------------
  // reset, registers, carrier
  // ------------------------------------------------------------
  logic rst_n;
  txb_ctl_if #(.VIDX_W(VIDX_W)) ctl ();

  txb_rst_sync u_rst (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .rst_b_out(rst_n)
  );

  txb_regs #(.VIDX_W(VIDX_W)) u_regs (
    .clk_in(CLK_IN),
    .rst_b_in(rst_n),
    .addr_in(REG_ADDR_IN),
    .wdata_in(REG_WDATA_IN),
    .wr_in(REG_WR_IN),
    .rd_in(REG_RD_IN),
    .rdata_out(REG_RDATA_OUT),
    .irq_out(IRQ_OUT),
    .ctl(ctl)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // header, packet bytes, then up to the next eight-byte boundary
  function automatic logic [17:0] next_hdr(input logic [17:0] o, input logic [15:0] len);
    logic [17:0] t;
    t = o + `TXB_HDR_BYTES + {2'b00, len} + 18'h0_0007;
    next_hdr = {t[17:3], 3'b000};
  endfunction

  // a whole header word must still fit inside the byte count
  function automatic logic hdr_fits(input logic [17:0] o, input logic [17:0] cnt);
    hdr_fits = (o + `TXB_HDR_BYTES) <= cnt;
  endfunction

  txb_pkg::fetch_e state_ff, nxt_state;
  logic [17:0] off_ff, nxt_off;
  logic [17:0] cnt_ff, nxt_cnt;
  logic [17:0] next_ff, nxt_next;
  logic [15:0] left_ff, nxt_left;
  logic [5:0] sel_ff, nxt_sel;
  logic irq_ff, nxt_irq;
  logic [31:0] data_ff, nxt_data;
  logic [2:0] bytes_ff, nxt_bytes;
  logic first_ff, nxt_first;
  logic last_ff, nxt_last;
  logic vins_ff, nxt_vins;
  logic [VIDX_W-1:0] vidx_ff, nxt_vidx;
  logic [31:0] vtag_ff, nxt_vtag;
  logic bad_hdr;
  logic [15:0] hdr_len;
  logic [3:0] hdr_kind;
  logic kind_ok;

  // header fields as they arrive from memory
  assign hdr_len = MEM_RDATA_IN[`TXB_LEN_MSB:0];
  assign hdr_kind = MEM_RDATA_IN[`TXB_KIND_MSB:`TXB_KIND_LSB];
  assign kind_ok = (hdr_kind == `TXB_KIND_TX);

  // ------------------------------------------------------------
  // fetch and parse state machine
  // ------------------------------------------------------------
  // next values; enqueues while busy are refused and flagged by the regs
  always_comb begin
    nxt_state = state_ff;
    nxt_off = off_ff;
    nxt_cnt = cnt_ff;
    nxt_next = next_ff;
    nxt_left = left_ff;
    nxt_sel = sel_ff;
    nxt_irq = irq_ff;
    nxt_data = data_ff;
    nxt_bytes = bytes_ff;
    nxt_first = first_ff;
    nxt_last = last_ff;
    nxt_vins = vins_ff;
    nxt_vidx = vidx_ff;
    nxt_vtag = vtag_ff;
    bad_hdr = 1'b0;
    case (state_ff)
      txb_pkg::S_IDLE: begin
        if (ctl.enq) begin
          nxt_cnt = {2'b00, ctl.enq_word[`TXB_CNT_MSB:0]};
          nxt_sel = ctl.enq_word[`TXB_SEL_MSB:`TXB_SEL_LSB];
          nxt_irq = ctl.enq_word[`TXB_IRQ_BIT];
          nxt_off = 18'h0_0000;
          nxt_state = hdr_fits(18'h0_0000, {2'b00, ctl.enq_word[`TXB_CNT_MSB:0]}) ?
                      txb_pkg::S_HDR : txb_pkg::S_DONE;
        end
      end
      txb_pkg::S_HDR: begin
        if (MEM_RD_ACK_IN) begin
          if (!kind_ok) begin
            bad_hdr = 1'b1;
            nxt_state = txb_pkg::S_DONE;
          end else begin
            nxt_next = next_hdr(off_ff, hdr_len);
            nxt_vins = MEM_RDATA_IN[`TXB_VINS_BIT];
            nxt_vidx = MEM_RDATA_IN[`TXB_VIDX_LSB +: VIDX_W];
            nxt_first = 1'b1;
            if (hdr_len == 16'h0000) begin
              nxt_off = next_hdr(off_ff, hdr_len);
              nxt_state = hdr_fits(next_hdr(off_ff, hdr_len), cnt_ff) ? txb_pkg::S_HDR : txb_pkg::S_DONE;
            end else begin
              nxt_off = off_ff + `TXB_HDR_BYTES;
              nxt_left = hdr_len;
              nxt_state = txb_pkg::S_DATA;
            end
          end
        end
      end
      txb_pkg::S_DATA: begin
        if (MEM_RD_ACK_IN) begin
          nxt_data = MEM_RDATA_IN;
          nxt_last = (left_ff <= 16'h0004);
          nxt_bytes = (left_ff <= 16'h0004) ? left_ff[2:0] : 3'h4;
          nxt_vtag = {`TXB_VLAN_TPID, ctl.vlan_tci};
          nxt_state = txb_pkg::S_PUSH;
        end
      end
      txb_pkg::S_PUSH: begin
        if (TX_READY_IN) begin
          nxt_first = 1'b0;
          if (last_ff) begin
            nxt_off = next_ff;
            nxt_state = hdr_fits(next_ff, cnt_ff) ? txb_pkg::S_HDR : txb_pkg::S_DONE;
          end else begin
            // padding to whole words lets every fetch stay word aligned
            nxt_left = left_ff - 16'h0004;
            nxt_off = off_ff + `TXB_HDR_BYTES;
            nxt_state = txb_pkg::S_DATA;
          end
        end
      end
      txb_pkg::S_DONE: begin
        nxt_state = txb_pkg::S_IDLE;
      end
      default: begin
        nxt_state = txb_pkg::S_IDLE;
      end
    endcase
  end

  // state registers
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= txb_pkg::S_IDLE;
      off_ff <= 18'h0_0000;
      cnt_ff <= 18'h0_0000;
      next_ff <= 18'h0_0000;
      left_ff <= 16'h0000;
      sel_ff <= 6'h00;
      irq_ff <= 1'b0;
      data_ff <= 32'h0000_0000;
      bytes_ff <= 3'h0;
      first_ff <= 1'b0;
      last_ff <= 1'b0;
      vins_ff <= 1'b0;
      vidx_ff <= '0;
      vtag_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      off_ff <= nxt_off;
      cnt_ff <= nxt_cnt;
      next_ff <= nxt_next;
      left_ff <= nxt_left;
      sel_ff <= nxt_sel;
      irq_ff <= nxt_irq;
      data_ff <= nxt_data;
      bytes_ff <= nxt_bytes;
      first_ff <= nxt_first;
      last_ff <= nxt_last;
      vins_ff <= nxt_vins;
      vidx_ff <= nxt_vidx;
      vtag_ff <= nxt_vtag;
    end
  end

  // ------------------------------------------------------------
  // outputs and carrier
  // ------------------------------------------------------------
  // request held until ack; address changes only after an ack
  assign MEM_RD_REQ_OUT = (state_ff == txb_pkg::S_HDR) || (state_ff == txb_pkg::S_DATA);
  assign MEM_BUF_SEL_OUT = sel_ff;
  assign MEM_ADDR_OUT = off_ff[15:0];
  assign TX_VALID_OUT = (state_ff == txb_pkg::S_PUSH);
  assign TX_DATA_OUT = data_ff;
  assign TX_BYTES_OUT = bytes_ff;
  assign TX_FIRST_OUT = first_ff;
  assign TX_LAST_OUT = last_ff;
  assign TX_VLAN_EN_OUT = vins_ff;
  assign TX_VLAN_TAG_OUT = vtag_ff;

  assign ctl.busy = (state_ff != txb_pkg::S_IDLE);
  assign ctl.done = (state_ff == txb_pkg::S_DONE);
  assign ctl.done_irq = irq_ff;
  assign ctl.bad_hdr = bad_hdr;
  assign ctl.offset = off_ff;
  assign ctl.vidx = vidx_ff;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!rst_n);

  enqueue_start_a: assert property (
    ctl.enq && !ctl.busy && ctl.enq_word[15:0] >= 16'h0004 |=> MEM_RD_REQ_OUT && (state_ff == txb_pkg::S_HDR))
    else $error("enqueue did not start a header fetch");
  count_loaded_a: assert property (
    ctl.enq && !ctl.busy |=> cnt_ff[15:0] == $past(ctl.enq_word[15:0]) && ctl.busy)
    else $error("byte count not taken from the enqueue word");
  buffer_select_a: assert property (
    ctl.enq && !ctl.busy |=> MEM_BUF_SEL_OUT == $past(ctl.enq_word[21:16]))
    else $error("wrong host buffer selected");
  first_header_a: assert property (
    ctl.enq && !ctl.busy |=> MEM_ADDR_OUT == 16'h0000)
    else $error("first fetch not at buffer start");
  data_follows_a: assert property (
    state_ff == txb_pkg::S_HDR && MEM_RD_ACK_IN && kind_ok && hdr_len != 16'h0000
    |=> state_ff == txb_pkg::S_DATA && MEM_ADDR_OUT == $past(MEM_ADDR_OUT) + 16'h0004)
    else $error("packet data not fetched right after header");
  unknown_kind_a: assert property (
    state_ff == txb_pkg::S_HDR && MEM_RD_ACK_IN && !kind_ok |=> state_ff == txb_pkg::S_DONE ##1 !ctl.busy)
    else $error("unknown header kind did not stop the walk");
  header_aligned_a: assert property (
    state_ff == txb_pkg::S_HDR |-> MEM_ADDR_OUT[2:0] == 3'h0)
    else $error("header fetch off an eight-byte boundary");
  last_bytes_a: assert property (
    TX_VALID_OUT |-> (TX_LAST_OUT ? (TX_BYTES_OUT != 3'h0 && TX_BYTES_OUT <= 3'h4) : TX_BYTES_OUT == 3'h4))
    else $error("byte count on the stream is wrong");
  vlan_tag_a: assert property (
    TX_VALID_OUT && TX_VLAN_EN_OUT |-> TX_VLAN_TAG_OUT[31:16] == `TXB_VLAN_TPID)
    else $error("vlan tag badly formed");
  push_hold_a: assert property (
    TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_DATA_OUT))
    else $error("stream word dropped under back-pressure");

  done_irq_c: cover property (ctl.done && ctl.done_irq ##1 IRQ_OUT);
  bad_kind_c: cover property (bad_hdr);
  vlan_pkt_c: cover property (TX_VALID_OUT && TX_VLAN_EN_OUT && TX_LAST_OUT && TX_READY_IN);
  stall_c: cover property ((TX_VALID_OUT && !TX_READY_IN) [*2] ##1 TX_READY_IN);
endmodule

// ==== rtl/txb_params.svh ====
// offsets, field positions, reset values and codes of the transmit burst fetch
// assumes byte addresses on the 8-bit register port, one 32-bit word per register
`ifndef TXB_PARAMS_SVH
`define TXB_PARAMS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define TXB_ENQ_OFS 8'h00
`define TXB_STAT_OFS 8'h04
`define TXB_MASK_OFS 8'h08
`define TXB_STATE_OFS 8'h0C
`define TXB_VLAN_OFS 8'h40

// ------------------------------------------------------------
// enqueue word fields
// ------------------------------------------------------------
`define TXB_CNT_MSB 15
`define TXB_SEL_MSB 21
`define TXB_SEL_LSB 16
`define TXB_IRQ_BIT 24
`define TXB_ENQ_USED 32'h013F_FFFF
`define TXB_ENQ_RST 32'h0000_0000

// ------------------------------------------------------------
// transmit header fields
// ------------------------------------------------------------
`define TXB_LEN_MSB 15
`define TXB_KIND_MSB 19
`define TXB_KIND_LSB 16
`define TXB_VIDX_LSB 24
`define TXB_VINS_BIT 28
`define TXB_KIND_TX 4'h2
`define TXB_VLAN_TPID 16'h8100
`define TXB_HDR_BYTES 18'h0_0004

// ------------------------------------------------------------
// status and mask bits, reset values
// ------------------------------------------------------------
`define TXB_ST_DONE 0
`define TXB_ST_BAD 1
`define TXB_ST_DROP 2
`define TXB_STAT_RST 3'h0
`define TXB_MASK_RST 3'h7

`endif

// ==== rtl/txb_pkg.sv ====
// types shared by the transmit burst fetch modules
// assumes nothing beyond a SystemVerilog compiler
package txb_pkg;

  // ------------------------------------------------------------
  // fetch states, one-hot
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_HDR = 5'h02,
    S_DATA = 5'h04,
    S_PUSH = 5'h08,
    S_DONE = 5'h10
  } fetch_e;

endpackage

// ==== rtl/txb_ctl_if.sv ====
// carrier between the register file and the fetch core
// assumes both ends sit on the same clock
`timescale 1ns/10ps
interface txb_ctl_if #(parameter int VIDX_W = 4);
  logic enq;
  logic [31:0] enq_word;
  logic busy;
  logic done;
  logic done_irq;
  logic bad_hdr;
  logic [17:0] offset;
  logic [VIDX_W-1:0] vidx;
  logic [15:0] vlan_tci;

  modport regs_mp(output enq, enq_word, vlan_tci, input busy, done, done_irq, bad_hdr, offset, vidx);
  modport core_mp(input enq, enq_word, vlan_tci, output busy, done, done_irq, bad_hdr, offset, vidx);
endinterface

// ==== rtl/txb_rst_sync.sv ====
// reset release synchroniser: asserts at once, releases after two edges
// assumes an active-low asynchronous reset pin
`timescale 1ns/10ps
module txb_rst_sync (
  input wire logic clk_in,
  input wire logic rst_b_in,
  output logic rst_b_out
);
  logic meta_ff;
  logic hold_ff;

  // second stage alone feeds the design
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else begin
      meta_ff <= 1'b1;
      hold_ff <= meta_ff;
    end
  end

  assign rst_b_out = hold_ff;
endmodule

// ==== rtl/txb_regs.sv ====
// register port slave: enqueue, status, mask, state and vlan tag table
// assumes single-cycle strobes, never read and write together
`timescale 1ns/10ps
`include "txb_params.svh"
module txb_regs #(
  parameter int VIDX_W = 4
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  output logic irq_out,
  txb_ctl_if.regs_mp ctl
);
  localparam int ENTRIES = 2 ** VIDX_W;
  localparam logic [8:0] VLAN_END = 9'(`TXB_VLAN_OFS) + 9'(4 * ENTRIES);

  logic [2:0] stat_ff, nxt_stat;
  logic [2:0] mask_ff, nxt_mask;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [15:0] vlan_ff [ENTRIES];
  logic [15:0] nxt_vlan [ENTRIES];

  // table window decode, used by write and read
  function automatic logic vlan_hit(input logic [7:0] a);
    vlan_hit = ({1'b0, a} >= 9'(`TXB_VLAN_OFS)) && ({1'b0, a} < VLAN_END);
  endfunction

  // ------------------------------------------------------------
  // enqueue strobe, reserved bits dropped here
  // ------------------------------------------------------------
  assign ctl.enq = wr_in && (addr_in == `TXB_ENQ_OFS);
  assign ctl.enq_word = wdata_in & `TXB_ENQ_USED;
  assign ctl.vlan_tci = vlan_ff[ctl.vidx];

  // next values: set wins over write-one-to-clear
  always_comb begin
    nxt_stat = stat_ff;
    nxt_mask = mask_ff;
    nxt_vlan = vlan_ff;
    nxt_rdata = 32'h0000_0000;
    if (wr_in && addr_in == `TXB_STAT_OFS) begin
      nxt_stat = stat_ff & ~wdata_in[2:0];
    end
    if (wr_in && addr_in == `TXB_MASK_OFS) begin
      nxt_mask = wdata_in[2:0];
    end
    if (wr_in && vlan_hit(addr_in)) begin
      nxt_vlan[addr_in[VIDX_W+1:2]] = wdata_in[15:0];
    end
    if (ctl.done && ctl.done_irq) begin
      nxt_stat[`TXB_ST_DONE] = 1'b1;
    end
    if (ctl.bad_hdr) begin
      nxt_stat[`TXB_ST_BAD] = 1'b1;
    end
    if (ctl.enq && ctl.busy) begin
      nxt_stat[`TXB_ST_DROP] = 1'b1;
    end
    if (rd_in) begin
      case (addr_in)
        `TXB_STAT_OFS: nxt_rdata = {29'h0, stat_ff};
        `TXB_MASK_OFS: nxt_rdata = {29'h0, mask_ff};
        `TXB_STATE_OFS: nxt_rdata = {ctl.busy, 13'h0, ctl.offset};
        default: nxt_rdata = vlan_hit(addr_in) ? {16'h0, vlan_ff[addr_in[VIDX_W+1:2]]} : 32'h0000_0000;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stat_ff <= `TXB_STAT_RST;
      mask_ff <= `TXB_MASK_RST;
      rdata_ff <= 32'h0000_0000;
      for (int i = 0; i < ENTRIES; i++) begin
        vlan_ff[i] <= 16'h0000;
      end
    end else begin
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      rdata_ff <= nxt_rdata;
      vlan_ff <= nxt_vlan;
    end
  end

  assign rdata_out = rdata_ff;
  assign irq_out = |(stat_ff & mask_ff);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  done_status_set_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ctl.done && ctl.done_irq |=> stat_ff[`TXB_ST_DONE])
    else $error("done status not set after requested completion");
  reserved_dropped_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ctl.enq |-> (ctl.enq_word[31:25] == 7'h00) && (ctl.enq_word[23:22] == 2'h0))
    else $error("reserved enqueue bits reached the core");
endmodule

// ==== verif/txb_host_mem.sv ====
// host memory model: word reads of the pre-allocated transmit buffers
// assumes each request is held steady until the one-cycle ack
`timescale 1ns/10ps
module txb_host_mem (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic slow_in,
  input wire logic req_in,
  input wire logic [5:0] sel_in,
  input wire logic [15:0] addr_in,
  output logic ack_out,
  output logic [31:0] rdata_out
);
  logic [31:0] mem [int];
  logic [31:0] last_ff;
  logic [1:0] wait_ff;

  // host fills a buffer before it is enqueued; sizes stay far below the maximum
  task automatic put(input logic [5:0] sel, input logic [15:0] ofs, input logic [31:0] w);
    mem[int'({sel, ofs})] = w;
  endtask

  // a word never written reads as all ones, not a friendly zero
  function automatic logic [31:0] word_at(input logic [5:0] s, input logic [15:0] a);
    int k;
    k = int'({s, a});
    return mem.exists(k) ? mem[k] : 32'hffff_ffff;
  endfunction

  // slow mode makes the request wait three cycles for its ack
  assign ack_out = req_in && (!slow_in || wait_ff == 2'h3);

  // data only with ack; otherwise the inverse of the last word so stale data never matches
  always_comb begin
    rdata_out = ack_out ? word_at(sel_in, addr_in) : ~last_ff;
  end

  // wait counter and last word returned
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wait_ff <= 2'h0;
      last_ff <= 32'h0000_0000;
    end else begin
      wait_ff <= (req_in && !ack_out) ? wait_ff + 2'h1 : 2'h0;
      if (ack_out) begin
        last_ff <= rdata_out;
      end
    end
  end
endmodule

// ==== verif/tx_burst_buffer_fetch_bench.sv ====
// self-checking bench: random burst buffers fetched and streamed, registers and interrupt
// assumes the host memory model beside the design and the register offsets of the params header
`timescale 1ns/10ps
`include "txb_params.svh"
module tx_burst_buffer_fetch_bench;
  typedef struct packed {
    logic [31:0] d;
    logic [2:0] b;
    logic f;
    logic l;
    logic v;
    logic [31:0] t;
  } word_s;
  logic clk, rst_b, wr, rd, irq, req, ack, valid, ready, slow, tx_first, tx_last, tx_ven;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, mdata, tx_data, tx_tag;
  logic [5:0] mem_sel, cur_sel;
  logic [15:0] mem_addr;
  logic [2:0] tx_bytes;
  logic [15:0] vtab [16];
  logic [31:0] seed = 32'h088c_5bb5;
  logic [31:0] d;
  word_s exp[$];
  word_s got[$];
  int num_errors = 0;
  int samples_checked = 0;

  tx_burst_buffer_fetch #(.VIDX_W(4)) DUT (.CLK_IN(clk), .RST_B_IN(rst_b), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .IRQ_OUT(irq),
    .MEM_RD_REQ_OUT(req), .MEM_BUF_SEL_OUT(mem_sel), .MEM_ADDR_OUT(mem_addr), .MEM_RD_ACK_IN(ack),
    .MEM_RDATA_IN(mdata), .TX_VALID_OUT(valid), .TX_DATA_OUT(tx_data), .TX_BYTES_OUT(tx_bytes),
    .TX_FIRST_OUT(tx_first), .TX_LAST_OUT(tx_last), .TX_VLAN_EN_OUT(tx_ven), .TX_VLAN_TAG_OUT(tx_tag),
    .TX_READY_IN(ready));

  txb_host_mem host_mem (.clk_in(clk), .rst_b_in(rst_b), .slow_in(slow), .req_in(req), .sel_in(mem_sel),
    .addr_in(mem_addr), .ack_out(ack), .rdata_out(mdata));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // bytes past the end of a packet are host padding, so they are not compared
  function automatic logic [31:0] bmask(input logic [2:0] b);
    return (b >= 3'h4) ? 32'hffff_ffff : ((32'h1 << (8 * b)) - 32'h1);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic close_out();
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one idle cycle after each access keeps strobes from being driven twice in a step
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask

  // lays packets into a buffer and records the words the stream must carry
  task automatic build(input logic [5:0] sel, input int npk, input logic bad, output logic [15:0] cnt);
    int off, len, n;
    logic [3:0] vi;
    logic v, last_bad;
    logic [31:0] w;
    word_s e;
    off = 0;
    for (int p = 0; p < npk; p++) begin
      len = rnd() % 14;
      vi = 4'(rnd());
      v = 1'(rnd());
      last_bad = bad && p == npk - 1;
      w = {3'h0, v, vi, 4'h0, last_bad ? 4'h5 : `TXB_KIND_TX, 16'(len)};
      host_mem.put(sel, 16'(off), w);
      n = (len + 3) / 4;
      for (int i = 0; i < n; i++) begin
        w = rnd();
        host_mem.put(sel, 16'(off + 4 + 4 * i), w);
        e = {w, 3'(i == n - 1 ? len - 4 * i : 4), 1'(i == 0), 1'(i == n - 1), v, `TXB_VLAN_TPID, vtab[vi]};
        if (!last_bad) exp.push_back(e);
      end
      off = (off + 4 + 4 * n + 7) / 8 * 8; // next header on an eight-byte boundary
    end
    cnt = 16'(off);
  endtask

  task automatic run_fetch(input int t);
    logic [5:0] sel;
    logic [15:0] cnt;
    logic [31:0] st;
    logic irqb, bad, drop;
    word_s g, e;
    sel = 6'(rnd());
    irqb = 1'(t);
    bad = (t == 3);
    drop = (t == 2);
    slow <= 1'(rnd());
    exp.delete();
    got.delete();
    cur_sel = sel;
    build(sel, drop ? 4 : 1 + rnd() % 4, bad, cnt);
    // count below one header word: the walk ends at once, nothing is fetched
    if (t == 7) begin
      cnt = 16'(rnd() % 4);
      exp.delete();
    end
    st = {7'(rnd()), irqb, 2'(rnd()), sel, cnt};
    wr_reg(`TXB_ENQ_OFS, st);
    if (drop) wr_reg(`TXB_ENQ_OFS, st);
    d = 32'hffff_ffff;
    for (int k = 0; k < 500 && d[31] !== 1'b0; k++) begin
      rd_reg(`TXB_STATE_OFS, d);
    end
    check(d & 32'h8000_0000, 32'h0);
    check(32'(got.size()), 32'(exp.size()));
    for (int i = 0; i < exp.size() && i < got.size(); i++) begin
      g = got[i];
      e = exp[i];
      check(g.d & bmask(e.b), e.d & bmask(e.b));
      check({27'h0, g.b, g.f, g.l}, {27'h0, e.b, e.f, e.l});
      check({31'h0, g.v}, {31'h0, e.v});
      if (e.v) check(g.t, e.t);
    end
    st = 32'h0;
    st[`TXB_ST_DONE] = irqb;
    st[`TXB_ST_BAD] = bad;
    st[`TXB_ST_DROP] = drop;
    rd_reg(`TXB_STAT_OFS, d);
    check(d, st);
    check({31'h0, irq}, {31'h0, st != 32'h0});
    if (t == 1) begin
      wr_reg(`TXB_MASK_OFS, 32'h0);
      check({31'h0, irq}, 32'h0);
      wr_reg(`TXB_MASK_OFS, 32'h7);
    end
    wr_reg(`TXB_STAT_OFS, 32'h7);
    rd_reg(`TXB_STAT_OFS, d);
    check(d, 32'h0);
    check({31'h0, irq}, 32'h0);
  endtask

  // ------------------------------------------------------------
  // clock, stream sink and watchdog
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // sink stalls at random; every read must name the enqueued buffer
  always @(posedge clk) begin
    if (valid === 1'b1 && ready === 1'b1) got.push_back({tx_data, tx_bytes, tx_first, tx_last, tx_ven, tx_tag});
    if (req === 1'b1) check({26'h0, mem_sel}, {26'h0, cur_sel});
    ready <= 1'(rnd()) | 1'(rnd());
  end

  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    close_out();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    slow = 1'b0;
    cur_sel = 6'h00;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(`TXB_MASK_OFS, d);
    check(d, 32'h7);
    rd_reg(`TXB_STAT_OFS, d);
    check(d, 32'h0);
    rd_reg(`TXB_ENQ_OFS, d);
    check(d, 32'h0);
    rd_reg(8'h30, d);
    check(d, 32'h0);
    for (int i = 0; i < 16; i++) begin
      vtab[i] = 16'(rnd());
      wr_reg(`TXB_VLAN_OFS + 8'(4 * i), {16'h0, vtab[i]});
    end
    for (int i = 0; i < 16; i++) begin
      rd_reg(`TXB_VLAN_OFS + 8'(4 * i), d);
      check(d, {16'h0, vtab[i]});
    end
    for (int t = 0; t < 8; t++) begin
      run_fetch(t);
    end
    close_out();
  end
endmodule
